// ---- rtl/mps_pin_select.sv ----
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
// How it works
// RULE1: Clock-run strap low disables, high enables clock-run
// RULE2: Arbiter strap low internal, high external arbiter
// RULE3: Pin 0 direction from control bit 0
// RULE4: Clock-run mode makes pin 0 clock-run input
// RULE5: Pin 1 direction bit 1; also power override
// RULE6: Pin 2 always general, direction bit 2
// RULE7: Pin 3 serial data on detect or force
// RULE8: Pin 4 serial clock on detect or force
// RULE9: Pull-ups 0,2,4 only in reset or input
// RULE10: No detect, no force keeps pin 3 general
// RULE11: Detect sampled once at reset release, held
module mps_pin_select
  import mps_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Classic Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [mps_pkg::MPS_AW-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [mps_pkg::MPS_DW-1:0] dat_i,
  output logic [mps_pkg::MPS_DW-1:0] dat_o,
  output logic ack_o,
  // Board straps
  input wire logic clock_run_strap,
  input wire logic arbiter_select_strap,
  // General pins: input level, drive and enable, pull-up on pins 0, 2, 4
  input wire logic [4:0] pin_in,
  output mps_pkg::mps_pads_t pads,
  output logic [2:0] pull_up_en,
  // Core-side functions
  output logic clock_run_enable,
  output logic external_arbiter_en,
  output logic clock_run_line,
  output logic power_override_input,
  output logic serial_bus_mode,
  input wire mps_pkg::mps_sb_req_t sb_req,
  output logic scl_in,
  output logic sda_in
);
  import mps_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  mps_state_t st_q; // Registered state
  mps_state_t st_d; // Next state
  logic sb_mode; // Serial-bus role active on pins 3 and 4
  logic bus_req; // New Wishbone request this cycle
  mps_reg_t reg_sel; // Decoded register

  // Address decode, shared by the read and the write path
  function automatic mps_reg_t mps_decode(input logic [MPS_AW-1:0] a);
    mps_reg_t r;
    r = MPS_REG_NONE;
    case (a)
      MPS_OFS_CTRL: r = MPS_REG_CTRL;
      MPS_OFS_DOUT: r = MPS_REG_DOUT;
      MPS_OFS_STAT: r = MPS_REG_STAT;
      default: r = MPS_REG_NONE;
    endcase
    return r;
  endfunction

  // Detected pull-up or the software force bit selects the serial bus
  assign sb_mode = st_q.sb_det | st_q.force_sb; // RULE7 RULE8 RULE10
  assign bus_req = cyc_i & stb_i & ~st_q.ack;
  assign reg_sel = mps_decode(adr_i);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    st_d = st_q;
    // Pins and straps come from off chip: two flops before anything looks
    st_d.pin_s1 = pin_in;
    st_d.pin_s2 = st_q.pin_s1;
    st_d.strap_s1 = {arbiter_select_strap, clock_run_strap};
    st_d.strap_s2 = st_q.strap_s1;
    // Straps are static; follow the synchronised level
    st_d.clk_run_en = st_q.strap_s2[0]; // RULE1
    st_d.ext_arb = st_q.strap_s2[1]; // RULE2
    // One-cycle answer, dropped in the cycle after it was given
    st_d.ack = bus_req;
    st_d.rdat = '0;
    if (bus_req && !we_i) begin
      // Read: unmapped addresses answer with zero
      case (reg_sel)
        MPS_REG_CTRL: begin
          st_d.rdat[MPS_CTRL_DIR_LSB +: MPS_NPINS] = st_q.dir;
          st_d.rdat[MPS_CTRL_FORCE_BIT] = st_q.force_sb;
        end
        MPS_REG_DOUT: begin
          st_d.rdat[4:0] = st_q.dout;
        end
        MPS_REG_STAT: begin
          st_d.rdat[MPS_STAT_PIN_LSB +: MPS_NPINS] = st_q.pin_s2;
          st_d.rdat[MPS_STAT_CLOCK_RUN_LINE_BIT] = st_q.clk_run_en;
          st_d.rdat[MPS_STAT_EXTARB_BIT] = st_q.ext_arb;
          st_d.rdat[MPS_STAT_SERIAL_BIT] = sb_mode;
          st_d.rdat[MPS_STAT_DETECT_BIT] = st_q.sb_det;
        end
        default: begin
          st_d.rdat = '0;
        end
      endcase
    end
    if (bus_req && we_i) begin
      // Write: byte lanes gate fields; unmapped writes are dropped
      case (reg_sel)
        MPS_REG_CTRL: begin
          if (sel_i[0]) begin
            st_d.dir = dat_i[MPS_CTRL_DIR_LSB +: MPS_NPINS]; // RULE3 RULE5 RULE6
          end
          if (sel_i[1]) begin
            st_d.force_sb = dat_i[MPS_CTRL_FORCE_BIT]; // RULE7 RULE8
          end
        end
        MPS_REG_DOUT: begin
          if (sel_i[0]) begin
            st_d.dout = dat_i[4:0];
          end
        end
        default: begin
          st_d.dout = st_q.dout;
        end
      endcase
    end
    // Pull-up detect is taken once, at the first edge out of reset
    if (!st_q.det_done) begin
      st_d.sb_det = st_q.pin_s2[4]; // RULE11
      st_d.det_done = 1'b1; // RULE11
    end
    // Pin 0: clock-run input in clock-run mode, else a general pin
    if (st_q.clk_run_en) begin
      st_d.pads.oe[0] = 1'b0; // RULE4
      st_d.pads.out[0] = 1'b0;
    end else begin
      st_d.pads.oe[0] = st_q.dir[0]; // RULE3
      st_d.pads.out[0] = st_q.dout[0];
    end
    // Pin 1: general pin; its level also feeds power override
    st_d.pads.oe[1] = st_q.dir[1]; // RULE5
    st_d.pads.out[1] = st_q.dout[1];
    // Pin 2 has no other role
    st_d.pads.oe[2] = st_q.dir[2]; // RULE6
    st_d.pads.out[2] = st_q.dout[2];
    // Pins 3 and 4: open-drain serial bus, else general pins
    if (sb_mode) begin
      st_d.pads.oe[3] = sb_req.sda_low; // RULE7
      st_d.pads.out[3] = 1'b0;
      st_d.pads.oe[4] = sb_req.scl_low; // RULE8
      st_d.pads.out[4] = 1'b0;
    end else begin
      st_d.pads.oe[3] = st_q.dir[3]; // RULE10
      st_d.pads.out[3] = st_q.dout[3];
      st_d.pads.oe[4] = st_q.dir[4]; // RULE8
      st_d.pads.out[4] = st_q.dout[4];
    end
    // Pull-ups only where the pin is a general-purpose input
    st_d.pull_en[0] = ~st_q.clk_run_en & ~st_q.dir[0]; // RULE9
    st_d.pull_en[1] = ~st_q.dir[2]; // RULE9
    st_d.pull_en[2] = ~sb_mode & ~st_q.dir[4]; // RULE9
    if (sys_rst) begin
      // Synchronous reset; synchronisers keep sampling so the
      // detect has a settled level the moment reset lets go
      st_d.clk_run_en = 1'b0;
      st_d.ext_arb = 1'b0;
      st_d.dir = MPS_DIR_RST;
      st_d.force_sb = MPS_FORCE_RST;
      st_d.dout = MPS_DOUT_RST;
      st_d.det_done = 1'b0;
      st_d.sb_det = 1'b0;
      st_d.pads = '0;
      st_d.pull_en = 3'h7; // RULE9
      st_d.ack = 1'b0;
      st_d.rdat = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Every field except the pin and strap synchronisers resets through the next-state logic above
  always_ff @(posedge clk) begin
    st_q <= st_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign dat_o = st_q.rdat;
  assign ack_o = st_q.ack;
  assign pads = st_q.pads;
  assign pull_up_en = st_q.pull_en;
  assign clock_run_enable = st_q.clk_run_en; // RULE1
  assign external_arbiter_en = st_q.ext_arb; // RULE2
  // Clock-run line reads high when the mode is off, as if pulled up
  assign clock_run_line = st_q.clk_run_en ? st_q.pin_s2[0] : 1'b1; // RULE4
  assign power_override_input = st_q.pin_s2[1]; // RULE5
  assign serial_bus_mode = sb_mode;
  // Serial lines idle high when the serial role is off
  assign scl_in = sb_mode ? st_q.pin_s2[4] : 1'b1; // RULE8
  assign sda_in = sb_mode ? st_q.pin_s2[3] : 1'b1; // RULE7

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // The first edge out of reset still shows the reset value, so skip it
  clock_run_line_strap_follow_a: assert property ( // RULE1
    !$past(sys_rst) |-> clock_run_enable == $past(st_q.strap_s2[0]))
    else $error("clock-run enable does not follow its strap");

  arbiter_strap_follow_a: assert property ( // RULE2
    !$past(sys_rst) |-> external_arbiter_en == $past(st_q.strap_s2[1]))
    else $error("arbiter select does not follow its strap");

  pin0_gp_dir_a: assert property ( // RULE3
    !st_q.clk_run_en && st_q.dir[0] && $stable(st_q.dir[0])
      && $stable(st_q.clk_run_en) |=> pads.oe[0])
    else $error("pin 0 not driven as configured output");

  pin0_clock_run_line_a: assert property ( // RULE4
    $past(st_q.clk_run_en) |-> !pads.oe[0] && clock_run_line == st_q.pin_s2[0])
    else $error("pin 0 driven or not routed in clock-run mode");

  pin1_dir_a: assert property ( // RULE5
    ##1 pads.oe[1] == $past(st_q.dir[1]))
    else $error("pin 1 enable does not follow its direction bit");

  pin2_dir_a: assert property ( // RULE6
    ##1 pads.oe[2] == $past(st_q.dir[2]) && pads.out[2] == $past(st_q.dout[2]))
    else $error("pin 2 does not follow its control bits");

  pin3_serial_a: assert property ( // RULE7
    sb_mode && $stable(sb_mode) |-> !pads.out[3] && pads.oe[3] == $past(sb_req.sda_low))
    else $error("pin 3 not open-drain serial data");

  pin4_serial_a: assert property ( // RULE8
    sb_mode && $stable(sb_mode) |-> !pads.out[4] && pads.oe[4] == $past(sb_req.scl_low))
    else $error("pin 4 not open-drain serial clock");

  pullup_input_a: assert property ( // RULE9
    ##1 (pull_up_en[1] == !$past(st_q.dir[2])
      && (!pull_up_en[0] || !pads.oe[0]) && (!pull_up_en[2] || !pads.oe[4])))
    else $error("pull-up enabled on a driven pin");

  pin3_general_a: assert property ( // RULE10
    !sb_mode && $stable(sb_mode) |-> pads.oe[3] == $past(st_q.dir[3]) && sda_in)
    else $error("pin 3 left its general role without detect or force");

  detect_hold_a: assert property ( // RULE11
    st_q.det_done |=> $stable(st_q.sb_det) && st_q.det_done)
    else $error("serial detect changed after reset release");

  serial_cov_c: cover property (st_q.sb_det ##1 sb_req.scl_low);
  force_cov_c: cover property (!st_q.sb_det && st_q.force_sb ##1 pads.oe[3]);
  clock_run_line_cov_c: cover property (clock_run_enable && !clock_run_line);
  write_cov_c: cover property (cyc_i && stb_i && we_i ##1 ack_o);

endmodule

// ---- common/mps_pkg.sv ----
// Shared constants and carriers for the misc pin function select block
package mps_pkg;

  // Pin count and bus widths
  localparam int MPS_NPINS = 5;
  localparam int MPS_AW = 8;
  localparam int MPS_DW = 32;

  // Register byte offsets
  localparam logic [7:0] MPS_OFS_CTRL = 8'h00;
  localparam logic [7:0] MPS_OFS_DOUT = 8'h04;
  localparam logic [7:0] MPS_OFS_STAT = 8'h08;

  // Control register fields
  localparam int MPS_CTRL_DIR_LSB = 0;
  localparam int MPS_CTRL_FORCE_BIT = 8;

  // Status register fields
  localparam int MPS_STAT_PIN_LSB = 0;
  localparam int MPS_STAT_CLOCK_RUN_LINE_BIT = 8;
  localparam int MPS_STAT_EXTARB_BIT = 9;
  localparam int MPS_STAT_SERIAL_BIT = 10;
  localparam int MPS_STAT_DETECT_BIT = 11;

  // Reset values
  localparam logic [4:0] MPS_DIR_RST = 5'h00;
  localparam logic [4:0] MPS_DOUT_RST = 5'h00;
  localparam logic MPS_FORCE_RST = 1'b0;

  // Register selector
  typedef enum {MPS_REG_CTRL, MPS_REG_DOUT, MPS_REG_STAT, MPS_REG_NONE} mps_reg_t;

  // Pad drive carrier: level driven and output enable, one bit per pin
  typedef struct packed {
    logic [4:0] out;
    logic [4:0] oe;
  } mps_pads_t;

  // Serial-bus controller requests: pull the line low while set
  typedef struct packed {
    logic scl_low;
    logic sda_low;
  } mps_sb_req_t;

  // Whole state of the block
  typedef struct packed {
    logic [4:0] pin_s1;
    logic [4:0] pin_s2;
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    logic clk_run_en;
    logic ext_arb;
    logic [4:0] dir;
    logic force_sb;
    logic [4:0] dout;
    logic det_done;
    logic sb_det;
    mps_pads_t pads;
    logic [2:0] pull_en;
    logic ack;
    logic [31:0] rdat;
  } mps_state_t;

endpackage

// ---- verif/mps_board_model.sv ----
`timescale 1ns/10ps
// Board side of the pins: external resistor on pin 4, host drivers, floating pads
module mps_board_model (
  // Clock
  input wire logic clk,
  // Device pad drive and internal pull-ups
  input wire mps_pkg::mps_pads_t pads,
  input wire logic [2:0] pull_up_en,
  // Board resistor on pin 4 (1 = pull-up, 0 = pull-down) and host drivers
  input wire logic scl_pull_up,
  input wire logic [4:0] ext_en,
  input wire logic [4:0] ext_val,
  // Resolved pad levels
  output logic [4:0] pin_in
);
  import mps_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Undriven pads with no pull wander so that no stale level passes
  logic wander_q = 1'b0;

  always_ff @(posedge clk) begin
    wander_q <= ~wander_q;
  end

  // Host beats device, device beats resistors; board resistor beats weak pull-up
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else if (pads.oe[i]) begin
        pin_in[i] = pads.out[i];
      end else if (i == 4) begin
        pin_in[i] = scl_pull_up;
      end else if ((i == 0 && pull_up_en[0]) || (i == 2 && pull_up_en[1])) begin
        pin_in[i] = 1'b1;
      end else begin
        pin_in[i] = wander_q;
      end
    end
  end
endmodule

// ---- verif/mps_pin_select_bench.sv ----
`timescale 1ns/10ps
// Self-checking bench for the pin function select block
module mps_pin_select_bench;
  import mps_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack_o;
  logic clock_run_strap = 1'b0;
  logic arbiter_select_strap = 1'b0;
  logic scl_pull_up = 1'b0;
  logic [4:0] ext_en = 5'h00;
  logic [4:0] ext_val = 5'h00;
  logic [4:0] pin_in;
  mps_pads_t pads;
  logic [2:0] pull_up_en;
  logic clock_run_enable, external_arbiter_en, clock_run_line;
  logic power_override_input, serial_bus_mode, scl_in, sda_in;
  mps_sb_req_t sb_req = '0;
  logic [31:0] rq;
  int failures = 0;
  int n_checks = 0;

  always #10 clk = ~clk;

  mps_pin_select u_dut (.clk(clk), .sys_rst(sys_rst), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .clock_run_strap(clock_run_strap), .arbiter_select_strap(arbiter_select_strap),
    .pin_in(pin_in), .pads(pads), .pull_up_en(pull_up_en),
    .clock_run_enable(clock_run_enable), .external_arbiter_en(external_arbiter_en),
    .clock_run_line(clock_run_line), .power_override_input(power_override_input),
    .serial_bus_mode(serial_bus_mode), .sb_req(sb_req), .scl_in(scl_in), .sda_in(sda_in));

  mps_board_model u_board (.clk(clk), .pads(pads), .pull_up_en(pull_up_en),
    .scl_pull_up(scl_pull_up), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  ////////////////////////////////////////////////////////////////
  // Compare, count and report
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Classic single cycle; holds the request until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    chk("wb ack", 32'(ack_o), 32'h0000_0001);
    rq = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk);
  endtask

  // Pin paths lag by up to three cycles
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Straps and the pin 4 resistor are set while reset is held
  task do_reset(input logic cr, input logic arb, input logic pu);
    @(posedge clk);
    clock_run_strap <= cr;
    arbiter_select_strap <= arb;
    scl_pull_up <= pu;
    ext_en <= 5'h00;
    sb_req <= '0;
    sys_rst <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    chk("pull_up_en in reset", 32'(pull_up_en), 32'h0000_0007);
    @(posedge clk);
    sys_rst <= 1'b0;
    settle;
  endtask

  ////////////////////////////////////////////////////////////////
  // Scenarios
  task t_straps;
    do_reset(1'b0, 1'b1, 1'b0);
    chk("clock_run_enable", 32'(clock_run_enable), 32'h0000_0000);
    chk("external_arbiter_en", 32'(external_arbiter_en), 32'h0000_0001);
    chk("serial_bus_mode", 32'(serial_bus_mode), 32'h0000_0000);
    wb(1'b0, MPS_OFS_STAT, 32'h0000_0000);
    chk("stat modes", rq & 32'h0000_0F00, 32'h0000_0200);
    wb(1'b0, 8'h0C, 32'h0000_0000);
    chk("unmapped read", rq, 32'h0000_0000);
    $display("test straps done");
  endtask

  task t_gpio;
    wb(1'b1, MPS_OFS_DOUT, 32'h0000_0015);
    wb(1'b1, MPS_OFS_CTRL, 32'h0000_001F);
    settle;
    chk("pads oe", 32'(pads.oe), 32'h0000_001F);
    chk("pads out", 32'(pads.out), 32'h0000_0015);
    chk("pull_up_en out", 32'(pull_up_en), 32'h0000_0000);
    wb(1'b0, MPS_OFS_CTRL, 32'h0000_0000);
    chk("ctrl readback", rq, 32'h0000_001F);
    wb(1'b0, MPS_OFS_DOUT, 32'h0000_0000);
    chk("dout readback", rq, 32'h0000_0015);
    wb(1'b1, MPS_OFS_CTRL, 32'h0000_0000);
    ext_en <= 5'h02;
    ext_val <= 5'h02;
    settle;
    chk("pull_up_en in", 32'(pull_up_en), 32'h0000_0007);
    chk("pads oe off", 32'(pads.oe), 32'h0000_0000);
    chk("power override high", 32'(power_override_input), 32'h0000_0001);
    ext_val <= 5'h00;
    settle;
    chk("power override low", 32'(power_override_input), 32'h0000_0000);
    $display("test gpio done");
  endtask

  task t_force;
    ext_en <= 5'h08;
    wb(1'b1, MPS_OFS_CTRL, 32'h0000_0118);
    settle;
    chk("serial mode forced", 32'(serial_bus_mode), 32'h0000_0001);
    chk("pads oe serial", 32'(pads.oe), 32'h0000_0000);
    chk("pull_up_en serial", 32'(pull_up_en), 32'h0000_0003);
    chk("sda_in", 32'(sda_in), 32'h0000_0000);
    sb_req <= 2'b11;
    settle;
    chk("scl sda drive oe", 32'(pads.oe), 32'h0000_0018);
    chk("scl_in", 32'(scl_in), 32'h0000_0000);
    chk("sda drive level", 32'(pads.out[3]), 32'h0000_0000);
    sb_req <= 2'b00;
    ext_en <= 5'h00;
    wb(1'b1, MPS_OFS_CTRL, 32'h0000_0018);
    settle;
    chk("force cleared", 32'(serial_bus_mode), 32'h0000_0000);
    chk("pins 3 4 general", 32'(pads.oe), 32'h0000_0018);
    chk("sda_in idle", 32'(sda_in), 32'h0000_0001);
    $display("test force done");
  endtask

  task t_clock_run_line;
    do_reset(1'b1, 1'b0, 1'b1);
    chk("clock_run_enable", 32'(clock_run_enable), 32'h0000_0001);
    chk("external_arbiter_en", 32'(external_arbiter_en), 32'h0000_0000);
    chk("serial by detect", 32'(serial_bus_mode), 32'h0000_0001);
    wb(1'b1, MPS_OFS_CTRL, 32'h0000_0001);
    settle;
    chk("pin 0 not driven", 32'(pads.oe[0]), 32'h0000_0000);
    chk("pin 0 pull-up off", 32'(pull_up_en[0]), 32'h0000_0000);
    ext_en <= 5'h01;
    ext_val <= 5'h00;
    settle;
    chk("clock_run_line low", 32'(clock_run_line), 32'h0000_0000);
    ext_val <= 5'h01;
    scl_pull_up <= 1'b0;
    settle;
    chk("clock_run_line high", 32'(clock_run_line), 32'h0000_0001);
    chk("detect held", 32'(serial_bus_mode), 32'h0000_0001);
    $display("test clock run done");
  endtask

  ////////////////////////////////////////////////////////////////
  // Verdict, main sequence and watchdog
  task stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    t_straps;
    t_gpio;
    t_force;
    t_clock_run_line;
    stop_test;
  end

  // Run needs well under a thousand cycles
  initial begin
    #100000;
    failures++;
    stop_test;
  end
endmodule
